/* File: wdh_ctrl.v */
// Notes on behaviour
// - Watchdog clock: RC oscillator or instruction clock.
// - Disabled watchdog ignores all watchdog operations; halt and the reset pin still clear its count.
// - Clock first divided by 256.
// - Prescaler field divides by two to code.
// - Running overflow: chip reset, set time-out.
// - Halted overflow: warm reset of PC, SP.
// - Reset pin, clear, halt clear watchdog.
// - Halt stops system oscillator; RC keeps running.
// - Halt keeps RAM, registers, port states.
// - Halt sets power-down, clears time-out; clear clears.
// - Wake on reset, interrupt, port edge, overflow.
// - Port A bits individually enabled for wake.
// - Disabled or stack-full interrupt resumes next instruction.
// - Wake waits 1024 clocks; vectored adds one.
// - Already pending interrupt cannot wake.
// - Time-out and power-down flags encode reset cause.
// - Start-up delay on power-up and wake only.
// - Reset clears watchdog, prescaler, puts core defaults.
// - RC mode drives clock divided by four out.
// - Time-out at status bit 5, power-down bit 4.
`timescale 1ns/1ns
`default_nettype none
`include "wdh_defines.vh"

module wdh_ctrl #(
   parameter IRQ_COUNT = 5,
   parameter PORT_BITS = 8
) (
   input  wire                 clock,
   input  wire                 srst,
   input  wire                 psel,
   input  wire                 penable,
   input  wire                 pwrite,
   input  wire [11:0]          paddr,
   input  wire [31:0]          pwdata,
   output reg  [31:0]          prdata,
   output reg                  pready,
   output reg                  pslverr,
   input  wire                 external_reset_pin_n,
   input  wire                 wdt_osc_clk,
   input  wire [PORT_BITS-1:0] port_a_pins,
   input  wire [IRQ_COUNT-1:0] irq_request,
   input  wire [IRQ_COUNT-1:0] irq_enable,
   input  wire                 stack_full,
   output reg                  chip_reset,
   output reg                  warm_reset,
   output reg                  core_run,
   output reg                  irq_vector_wake,
   output reg                  halted,
   output reg                  sys_osc_en,
   output reg                  hold_io,
   output reg                  osc_output_pin,
   output reg                  osc_output_pin_oe_n,
   output reg                  timeout_flag,
   output reg                  powerdown_flag
);

   localparam [2:0] ST_START = 3'd0;
   localparam [2:0] ST_RUN   = 3'd1;
   localparam [2:0] ST_HALT  = 3'd2;
   localparam [2:0] ST_WAKE  = 3'd3;
   localparam [2:0] ST_VEC   = 3'd4;

   // Counter spans the base stages plus the largest prescale
   localparam CNT_BITS = `WDH_BASE_DIV_BITS + 7;
   localparam integer DLY_LAST_I = `WDH_STARTUP_CYCLES - 1;
   localparam [9:0] DLY_LAST = DLY_LAST_I[9:0];

   // Terminal mask: 256 base counts times 2**sel
   function [CNT_BITS-1:0] wdh_tmask;
      input [2:0] sel;
      reg   [CNT_BITS:0] one_hot;
      begin
         one_hot = {{CNT_BITS{1'b0}}, 1'b1} << (`WDH_BASE_DIV_BITS + sel);
         wdh_tmask = one_hot[CNT_BITS-1:0] - {{(CNT_BITS-1){1'b0}}, 1'b1};
      end
   endfunction

   function wdh_hit;
      input [11:0] addr;
      input [7:0]  idx;
      begin
         wdh_hit = (addr == {2'b00, idx, 2'b00});
      end
   endfunction

   reg  [2:0]           state;
   reg  [2:0]           next_state;
   reg  [9:0]           dly;
   reg  [CNT_BITS-1:0]  wdt_cnt;
   reg  [7:0]           prescale;
   reg  [15:0]          option;
   reg                  option_locked;
   reg  [1:0]           instr_div;
   // Requests pending at halt entry cannot wake
   reg  [IRQ_COUNT-1:0] irq_snap;
   reg                  wake_vec;
   reg                  next_wake_vec;
   reg  [9:0]           next_dly;
   reg                  next_chip_reset;
   reg                  next_warm_reset;
   reg                  next_core_run;
   reg                  next_halted;
   reg  [CNT_BITS-1:0]  next_wdt_cnt;
   reg                  next_timeout;
   reg                  next_powerdown;
   reg  [7:0]           next_prescale;
   reg  [31:0]          next_prdata;
   reg                  next_pslverr;
   // Pin synchroniser stages
   reg                  rst_s1;
   reg                  rst_s2;
   reg                  wosc_s1;
   reg                  wosc_s2;
   reg                  wosc_s3;
   reg  [PORT_BITS-1:0] pa_s1;
   reg  [PORT_BITS-1:0] pa_s2;
   reg  [PORT_BITS-1:0] pa_s3;

   // Decoded bus strobes and wake events
   wire                 apb_acc;
   wire                 apb_wr;
   wire                 wdt_on;
   wire                 tick;
   wire                 cmd_wr;
   wire                 clr_cmd;
   wire                 halt_cmd;
   wire                 ext_low;
   wire                 ovf;
   wire                 pa_wake;
   wire [IRQ_COUNT-1:0] irq_new;
   wire                 irq_wake;
   wire                 irq_vec;
   wire                 any_wake;
   wire                 dly_done;
   wire [CNT_BITS-1:0]  tmask;

   assign apb_acc  = psel & penable & ~pready;
   assign apb_wr   = psel & penable & pready & pwrite;
   assign wdt_on   = option[`WDH_OPT_ENABLE_BIT];
   assign ext_low  = ~rst_s2;
   assign cmd_wr   = apb_wr & wdh_hit(paddr, `WDH_IDX_COMMAND);
   assign clr_cmd  = cmd_wr & pwdata[`WDH_CMD_CLEAR_BIT] & wdt_on;
   assign halt_cmd = cmd_wr & pwdata[`WDH_CMD_HALT_BIT]
                     & (state == ST_RUN) & ~ext_low;
   // RC ticks keep coming in halt; instruction ticks stop with the oscillator
   assign tick     = option[`WDH_OPT_RCSRC_BIT] ? (wosc_s2 & ~wosc_s3)
                     : (instr_div == 2'b11) & (state != ST_HALT);
   assign tmask    = wdh_tmask(prescale[`WDH_SEL_MSB:`WDH_SEL_LSB]);
   assign ovf      = wdt_on & tick & ((wdt_cnt & tmask) == tmask) & ~ext_low;
   assign pa_wake  = |(option[`WDH_OPT_WAKE_MSB:`WDH_OPT_WAKE_LSB]
                       & pa_s3 & ~pa_s2);
   assign irq_new  = irq_request & ~irq_snap;
   assign irq_wake = |irq_new;
   assign irq_vec  = |(irq_new & irq_enable) & ~stack_full;
   assign any_wake = ext_low | ovf | pa_wake | irq_wake;
   assign dly_done = (dly == DLY_LAST);

   always @* begin
      next_state = state;
      case (state)
         ST_START: begin
            if (dly_done) begin
               next_state = ST_RUN;
            end
         end
         ST_RUN: begin
            if (halt_cmd) begin
               next_state = ST_HALT;
            end
         end
         ST_HALT: begin
            if (any_wake) begin
               next_state = ST_WAKE;
            end
         end
         ST_WAKE: begin
            if (dly_done) begin
               next_state = wake_vec ? ST_VEC : ST_RUN;
            end
         end
         ST_VEC: begin
            next_state = ST_RUN;
         end
         default: begin
            next_state = ST_START;
         end
      endcase
   end

   // Delay counter restarts on every state change
   always @* begin
      if (next_state != state) begin
         next_dly = 10'h000;
      end else begin
         next_dly = dly + 10'h001;
      end
   end

   // Vectored wake only when an enabled request alone ends halt
   always @* begin
      next_wake_vec = wake_vec;
      if (state == ST_HALT && any_wake) begin
         next_wake_vec = irq_wake & irq_vec & ~ext_low & ~ovf & ~pa_wake;
      end
   end

   // Pin reset needs no start-up delay while running
   always @* begin
      next_chip_reset = ext_low | (ovf & (state != ST_HALT));
      next_warm_reset = ovf & (state == ST_HALT);
      next_core_run   = (next_state == ST_RUN) | (next_state == ST_VEC);
      next_halted     = (next_state == ST_HALT);
   end

   // Watchdog count; only bits under the terminal mask matter
   always @* begin
      next_wdt_cnt = wdt_cnt;
      if (ext_low | clr_cmd | halt_cmd | ovf) begin
         next_wdt_cnt = {CNT_BITS{1'b0}};
      end else if (wdt_on & tick) begin
         next_wdt_cnt = wdt_cnt + {{(CNT_BITS-1){1'b0}}, 1'b1};
      end
   end

   // Reset-cause flags; a time-out in the same cycle as a clear wins
   always @* begin
      next_timeout   = timeout_flag;
      next_powerdown = powerdown_flag;
      if (halt_cmd) begin
         next_powerdown = 1'b1;
         next_timeout   = 1'b0;
      end else if (clr_cmd) begin
         next_powerdown = 1'b0;
         next_timeout   = 1'b0;
      end
      if (ovf) begin
         next_timeout = 1'b1;
      end
   end

   // Prescale: chip-reset events (pin low, running overflow) win over a bus write in the same cycle
   always @* begin
      next_prescale = prescale;
      if (apb_wr & wdh_hit(paddr, `WDH_IDX_PRESCALE) & wdt_on) begin
         next_prescale = pwdata[7:0];
      end
      if (ext_low | (ovf & (state != ST_HALT))) begin
         next_prescale = `WDH_PRESCALE_RESET;
      end
   end

   // Read mux, decoded in the cycle before pready rises
   always @* begin
      next_prdata  = 32'h0000_0000;
      next_pslverr = 1'b0;
      if (wdh_hit(paddr, `WDH_IDX_PRESCALE)) begin
         next_prdata = {24'h00_0000, prescale};
      end else if (wdh_hit(paddr, `WDH_IDX_STATUS)) begin
         next_prdata = {26'h000_0000, timeout_flag, powerdown_flag,
                        4'h0};
      end else if (wdh_hit(paddr, `WDH_IDX_COMMAND)) begin
         next_prdata = {29'h0000_0000, state};
      end else if (wdh_hit(paddr, `WDH_IDX_OPTION)) begin
         next_prdata = {15'h0000, option_locked, option};
      end else begin
         next_pslverr = 1'b1;
      end
   end

   // Pin synchronisers; the third stages only feed edge detectors
   always @(posedge clock) begin
      if (srst) begin
         rst_s1  <= 1'b1;
         rst_s2  <= 1'b1;
         wosc_s1 <= 1'b0;
         wosc_s2 <= 1'b0;
         wosc_s3 <= 1'b0;
         pa_s1   <= {PORT_BITS{1'b1}};
         pa_s2   <= {PORT_BITS{1'b1}};
         pa_s3   <= {PORT_BITS{1'b1}};
      end else begin
         rst_s1  <= external_reset_pin_n;
         rst_s2  <= rst_s1;
         wosc_s1 <= wdt_osc_clk;
         wosc_s2 <= wosc_s1;
         wosc_s3 <= wosc_s2;
         pa_s1   <= port_a_pins;
         pa_s2   <= pa_s1;
         pa_s3   <= pa_s2;
      end
   end

   // Sequencer, start-up and wake delay
   always @(posedge clock) begin
      if (srst) begin
         state           <= ST_START;
         dly             <= 10'h000;
         wake_vec        <= 1'b0;
         irq_snap        <= {IRQ_COUNT{1'b0}};
         chip_reset      <= 1'b1;
         warm_reset      <= 1'b0;
         core_run        <= 1'b0;
         irq_vector_wake <= 1'b0;
         halted          <= 1'b0;
         sys_osc_en      <= 1'b1;
         hold_io         <= 1'b0;
      end else begin
         state           <= next_state;
         dly             <= next_dly;
         if (halt_cmd) begin
            irq_snap <= irq_request;
         end
         wake_vec        <= next_wake_vec;
         chip_reset      <= next_chip_reset;
         warm_reset      <= next_warm_reset;
         core_run        <= next_core_run;
         irq_vector_wake <= (state == ST_VEC);
         halted          <= next_halted;
         sys_osc_en      <= ~next_halted;
         hold_io         <= next_halted;
      end
   end

   // Watchdog counter and reset-cause flags
   always @(posedge clock) begin
      if (srst) begin
         wdt_cnt        <= {CNT_BITS{1'b0}};
         timeout_flag   <= 1'b0;
         powerdown_flag <= 1'b0;
      end else begin
         wdt_cnt        <= next_wdt_cnt;
         timeout_flag   <= next_timeout;
         powerdown_flag <= next_powerdown;
      end
   end

   // Instruction clock divider and its pin copy
   always @(posedge clock) begin
      if (srst) begin
         instr_div           <= 2'b00;
         osc_output_pin      <= 1'b0;
         osc_output_pin_oe_n <= 1'b1;
      end else begin
         if (state != ST_HALT) begin
            instr_div <= instr_div + 2'b01;
         end
         osc_output_pin      <= instr_div[1];
         osc_output_pin_oe_n <= ~option[`WDH_OPT_RCMODE_BIT];
      end
   end

   // APB slave, one wait state
   always @(posedge clock) begin
      if (srst) begin
         prescale      <= `WDH_PRESCALE_RESET;
         option        <= `WDH_OPTION_RESET;
         option_locked <= 1'b0;
         prdata        <= 32'h0000_0000;
         pready        <= 1'b0;
         pslverr       <= 1'b0;
      end else begin
         pready   <= apb_acc;
         pslverr  <= apb_acc & next_pslverr;
         if (apb_acc) begin
            prdata <= next_prdata;
         end
         prescale <= next_prescale;
         // Option bits are one-time writable, like fuses
         if (apb_wr & wdh_hit(paddr, `WDH_IDX_OPTION) & ~option_locked) begin
            option        <= pwdata[15:0];
            option_locked <= 1'b1;
         end
      end
   end

endmodule
`default_nettype wire

/* File: wdh_defines.vh */
`ifndef WDH_DEFINES_VH
`define WDH_DEFINES_VH

// Register indices; byte address is four times the index
`define WDH_IDX_PRESCALE     8'h09
`define WDH_IDX_STATUS       8'h0a
`define WDH_IDX_COMMAND      8'h10
`define WDH_IDX_OPTION       8'h11

// Prescale control fields and reset value
`define WDH_PRESCALE_RESET   8'h07
`define WDH_SEL_LSB          0
`define WDH_SEL_MSB          2

// Status fields
`define WDH_STATUS_PDF_BIT   4
`define WDH_STATUS_TO_BIT    5

// Command fields (write), state readback (read)
`define WDH_CMD_CLEAR_BIT    0
`define WDH_CMD_HALT_BIT     1

// Option fields, writable once after power-up
`define WDH_OPT_ENABLE_BIT   0
`define WDH_OPT_RCSRC_BIT    1
`define WDH_OPT_RCMODE_BIT   2
`define WDH_OPT_WAKE_LSB     8
`define WDH_OPT_WAKE_MSB     15
`define WDH_OPTION_RESET     16'h0001

// Timing
`define WDH_BASE_DIV_BITS    8
`define WDH_STARTUP_CYCLES   1024
`define WDH_INSTR_DIV        4

`endif

/* File: wdh_ctrl_assertions.sv */
`timescale 1ns/1ns
`default_nettype none
module wdh_ctrl_assertions (
   input wire logic        clock,
   input wire logic        srst,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        external_reset_pin_n,
   input wire logic        chip_reset,
   input wire logic        warm_reset,
   input wire logic        core_run,
   input wire logic        halted,
   input wire logic        sys_osc_en,
   input wire logic        hold_io,
   input wire logic        osc_output_pin,
   input wire logic        timeout_flag,
   input wire logic        powerdown_flag
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (srst);
   logic [2:0] run_cnt;
   logic [10:0] dark_cnt;
   // Cycles without core_run since reset or halt exit, saturating
   always_ff @(posedge clock) begin
      if (srst || halted || core_run)
         dark_cnt <= 11'h000;
      else if (dark_cnt != 11'h7ff)
         dark_cnt <= dark_cnt + 11'h001;
   end
   // Cycles spent out of halt, saturating, so the divider has settled
   always_ff @(posedge clock) begin
      if (srst || halted)
         run_cnt <= 3'h0;
      else if (run_cnt != 3'h7)
         run_cnt <= run_cnt + 3'h1;
   end
   property p_halt_flags;
      $rose(halted) |-> powerdown_flag && !timeout_flag;
   endproperty
   a_halt_flags: assert property (p_halt_flags)
      else $error("flags wrong on halt entry");
   property p_osc_stop;
      halted |-> !sys_osc_en;
   endproperty
   a_osc_stop: assert property (p_osc_stop)
      else $error("system oscillator enabled while halted");
   property p_hold_io;
      halted |-> hold_io;
   endproperty
   a_hold_io: assert property (p_hold_io)
      else $error("ports not held while halted");
   property p_freeze;
      halted ##1 halted ##1 halted |-> $stable(osc_output_pin);
   endproperty
   a_freeze: assert property (p_freeze)
      else $error("divided clock moves while halted");
   property p_osc_div;
      run_cnt == 3'h7 |-> osc_output_pin != $past(osc_output_pin, 2);
   endproperty
   a_osc_div: assert property (p_osc_div)
      else $error("divided clock output not clock over four");
   property p_warm;
      $rose(warm_reset) |-> ##[0:2] (timeout_flag && powerdown_flag);
   endproperty
   a_warm: assert property (p_warm)
      else $error("flags wrong after halted overflow");
   property p_run_reset;
      $rose(timeout_flag) && !powerdown_flag |-> ##[0:2] chip_reset;
   endproperty
   a_run_reset: assert property (p_run_reset)
      else $error("running overflow gave no chip reset");
   property p_wake_delay;
      $rose(core_run) |-> dark_cnt >= 11'd1016 && dark_cnt <= 11'd1030;
   endproperty
   a_wake_delay: assert property (p_wake_delay)
      else $error("wake delay wrong");
   property p_startup;
      !core_run |-> dark_cnt <= 11'd1030;
   endproperty
   a_startup: assert property (p_startup)
      else $error("start-up delay wrong");
   property p_pin_reset;
      (!external_reset_pin_n)[*4] |-> chip_reset;
   endproperty
   a_pin_reset: assert property (p_pin_reset)
      else $error("reset pin low without chip reset");
   property p_status;
      pready && !pwrite && paddr == 12'h028
         |-> prdata[5:4] == {timeout_flag, powerdown_flag};
   endproperty
   a_status: assert property (p_status)
      else $error("status read does not show flags");
   c_warm: cover property ($rose(warm_reset));
   c_wake: cover property ($fell(halted));
   c_crst: cover property ($rose(timeout_flag) && !powerdown_flag);
endmodule
bind wdh_ctrl wdh_ctrl_assertions wdh_ctrl_assertions_inst (
   .clock, .srst, .pwrite, .paddr, .prdata, .pready, .external_reset_pin_n,
   .chip_reset, .warm_reset, .core_run, .halted, .sys_osc_en, .hold_io,
   .osc_output_pin, .timeout_flag, .powerdown_flag);
`default_nettype wire

/* File: test_watchdog_halt_reset_ctrl.sv */
`timescale 1ns/1ns
`default_nettype none
module test_watchdog_halt_reset_ctrl;
   logic        clock = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0;
   logic        pwrite = 1'b0, external_reset_pin_n = 1'b1;
   logic        wdt_osc_clk = 1'b0, stack_full = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [7:0]  port_a_pins = 8'hff, ev;
   logic [4:0]  irq_request = 5'h00, irq_enable = 5'h00;
   logic        pready, pslverr, chip_reset, warm_reset, core_run, halted;
   logic        irq_vector_wake, sys_osc_en, hold_io, osc_output_pin;
   logic        osc_output_pin_oe_n, timeout_flag, powerdown_flag, err;
   int          num_errors = 0, compares = 0, n;
   localparam W_TO = 1, W_RUN = 2, W_HALT = 3, W_AWAKE = 4, W_VEC = 6;
   localparam W_WARM = 7;
   assign ev = {warm_reset, irq_vector_wake, chip_reset, ~halted, halted,
                core_run, timeout_flag, 1'b0};
   wdh_ctrl wdh_ctrl_inst (.clock, .srst, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .external_reset_pin_n,
      .wdt_osc_clk, .port_a_pins, .irq_request, .irq_enable, .stack_full,
      .chip_reset, .warm_reset, .core_run, .irq_vector_wake, .halted,
      .sys_osc_en, .hold_io, .osc_output_pin, .osc_output_pin_oe_n,
      .timeout_flag, .powerdown_flag);
   initial forever #2 clock = ~clock;
   // Free-running watchdog oscillator, unrelated in phase
   initial begin
      #5;
      forever #12 wdt_osc_clk = ~wdt_osc_clk;
   end
   task chk(input string what, input logic [31:0] exp, got);
      compares++;
      if (got !== exp) begin
         $display("mismatch %s expected %h seen %h", what, exp, got);
         num_errors++;
      end
   endtask
   task rng(input string what, input int lo, hi);
      compares++;
      if (n < lo || n > hi) begin
         $display("mismatch %s expected %0d..%0d seen %0d", what, lo, hi, n);
         num_errors++;
      end
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (pready !== 1'b1 && n < 20);
      chk("pready", 32'h1, {31'h0, pready});
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clock);
   endtask
   task wait_on(input int s, input int lim);
      n = 0;
      while (ev[s] !== 1'b1 && n < lim) begin
         @(posedge clock);
         n++;
      end
   endtask
   task t_regs;
      apb(1'b0, 12'h024, 32'h0);
      chk("prescale reset", 32'h7, rd);
      apb(1'b1, 12'h044, 32'h105);
      @(posedge clock);
      chk("osc out enable", 32'h0, {31'h0, osc_output_pin_oe_n});
      apb(1'b0, 12'h0fc, 32'h0);
      chk("unmapped error", 32'h1, {31'h0, err});
      $display("registers done");
   endtask
   task t_overflow(input logic [2:0] sel);
      apb(1'b1, 12'h024, {29'h0, sel});
      apb(1'b1, 12'h040, 32'h1);
      chk("timeout cleared", 32'h0, {31'h0, timeout_flag});
      wait_on(W_TO, 3000);
      rng("overflow period", (1024 << sel) - 8, (1024 << sel) + 6);
      apb(1'b0, 12'h024, 32'h0);
      chk("prescale after reset", 32'h7, rd);
      $display("overflow done");
   endtask
   task t_pin;
      external_reset_pin_n <= 1'b0;
      repeat (6) @(posedge clock);
      chk("pin chip reset", 32'h1, {31'h0, chip_reset});
      external_reset_pin_n <= 1'b1;
      repeat (4) @(posedge clock);
      chk("flags kept", 32'h1, {31'h0, timeout_flag});
      apb(1'b1, 12'h040, 32'h1);
      apb(1'b0, 12'h028, 32'h0);
      chk("status cleared", 32'h0, rd);
      $display("pin reset done");
   endtask
   task t_port;
      wait_on(W_RUN, 3000);
      apb(1'b1, 12'h040, 32'h2);
      wait_on(W_HALT, 4);
      chk("halted", 32'h1, {31'h0, halted});
      chk("halt flags", 32'h1, {30'h0, timeout_flag, powerdown_flag});
      chk("osc off", 32'h0, {31'h0, sys_osc_en});
      chk("io held", 32'h1, {31'h0, hold_io});
      port_a_pins <= 8'hfd;
      wait_on(W_AWAKE, 20);
      rng("masked bit no wake", 20, 20);
      port_a_pins <= 8'hfc;
      wait_on(W_AWAKE, 20);
      rng("port wake", 0, 6);
      wait_on(W_RUN, 1100);
      rng("wake delay", 1016, 1030);
      port_a_pins <= 8'hff;
      $display("port wake done");
   endtask
   task t_irq;
      srst <= 1'b1;
      repeat (4) @(posedge clock);
      srst <= 1'b0;
      @(posedge clock);
      apb(1'b1, 12'h044, 32'h3);
      wait_on(W_RUN, 1100);
      irq_enable <= 5'h03;
      irq_request <= 5'h02;
      apb(1'b1, 12'h040, 32'h2);
      wait_on(W_AWAKE, 30);
      rng("pending irq no wake", 30, 30);
      irq_request <= 5'h03;
      wait_on(W_VEC, 1100);
      rng("vectored wake", 1016, 1032);
      irq_request <= 5'h00;
      $display("irq wake done");
   endtask
   task t_warm;
      wait_on(W_RUN, 10);
      apb(1'b1, 12'h024, 32'h0);
      apb(1'b1, 12'h040, 32'h2);
      wait_on(W_WARM, 2000);
      rng("halted overflow", 1500, 1560);
      chk("warm flags", 32'h3, {30'h0, timeout_flag, powerdown_flag});
      chk("no chip reset", 32'h0, {31'h0, chip_reset});
      $display("warm reset done");
   endtask
   task tally_and_finish;
      $display("comparisons %0d mismatches %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      #200000;
      num_errors++;
      tally_and_finish;
   end
   initial begin
      repeat (4) @(posedge clock);
      srst <= 1'b0;
      @(posedge clock);
      t_regs;
      t_overflow(3'h0);
      t_overflow(3'h1);
      t_pin;
      t_port;
      t_irq;
      t_warm;
      tally_and_finish;
   end
endmodule
`default_nettype wire
